// >>> dma_defines.svh
// register offsets, field positions and reset values of the dma block
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH
`define CH_NUM 4
`define R_CON 3'h0
`define R_REQ 3'h1
`define R_STAH 3'h2
`define R_STAL 3'h3
`define R_STBH 3'h4
`define R_STBL 3'h5
`define R_PAD 3'h6
`define R_CNT 3'h7
`define S_PWC 3'h0
`define S_RQC 3'h1
`define S_LCA 3'h2
`define S_ADRH 3'h3
`define S_ADRL 3'h4
`define S_PPS 3'h5
`define CON_CHANNEL_ON 15
`define CON_SIZE 14
`define CON_DIR 13
`define CON_HALF 12
`define CON_NULL_WRITE_SELECT 11
`define CON_WMASK 16'hF833
`define REQ_FORCE 15
`define AM_POSTINC 2'h0
`define AM_PERIND 2'h2
`define TRIG_CAN_RX 8'h22
`define TRIG_CAN_TX 8'h46
`define LCA_RESET 4'hF
`endif

// >>> dma_pkg.sv
// types shared by the dma control block and its data mover
package dma_pkg;
  typedef struct packed {
    logic [15:0] con;
    logic force_on;
    logic [7:0] trig;
    logic [7:0] sta_h;
    logic [15:0] sta_l;
    logic [7:0] stb_h;
    logic [15:0] stb_l;
    logic [15:0] pad;
    logic [13:0] cnt;
    logic [23:0] cur;
    logic [13:0] done;
    logic pp;
    logic pend;
  } chan_t;
  typedef struct packed {
    logic start;
    logic forced;
    logic dir;
    logic byte_mode;
    logic null_write_select;
    logic [23:0] ram_addr;
    logic [15:0] per_addr;
  } move_req_t;
  typedef enum logic [1:0] {
    MV_IDLE = 2'b00,
    MV_READ = 2'b01,
    MV_WRITE = 2'b11,
    MV_NULL = 2'b10
  } mv_state_t;
endpackage : dma_pkg

// >>> dma_move_if.sv
// carrier between channel control and the data mover
`timescale 1ns/1ps
`default_nettype none
interface dma_move_if;
  logic start;
  logic dir;
  logic byte_mode;
  logic null_write_select;
  logic [23:0] ram_addr;
  logic [15:0] per_addr;
  logic done;
  modport ctrl (output start, dir, byte_mode, null_write_select, ram_addr, per_addr, input done);
  modport mover (input start, dir, byte_mode, null_write_select, ram_addr, per_addr, output done);
endinterface : dma_move_if
`default_nettype wire

// >>> dma_mover.sv
// moves one element: source read, destination write, optional null write
`timescale 1ns/1ps
`default_nettype none
module dma_mover
  import dma_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dma_move_if.mover mv,
  output logic bus_req,
  output logic bus_ram,
  output logic bus_we,
  output logic bus_byte,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);
  typedef struct packed {
    mv_state_t st;
    logic req;
    logic ram;
    logic we;
    logic byte_mode;
    logic dir;
    logic null_write_select;
    logic [23:0] addr;
    logic [23:0] ram_a;
    logic [15:0] per_a;
    logic [15:0] data;
    logic done;
  } mv_t;
  mv_t q, d;

  always_comb
  begin
    d = q;
    d.done = 1'b0;
    case (q.st)
      MV_IDLE:
        if (mv.start)
        begin
          d.dir = mv.dir;
          d.null_write_select = mv.null_write_select;
          d.byte_mode = mv.byte_mode;
          d.ram_a = mv.ram_addr;
          d.per_a = mv.per_addr;
          d.st = MV_READ;
          d.req = 1'b1;
          d.we = 1'b0;
          d.ram = mv.dir;
          d.addr = mv.dir ? mv.ram_addr : {8'h00, mv.per_addr};
        end
      MV_READ:
        if (bus_ack)
        begin
          d.data = q.byte_mode ? {8'h00, bus_rdata[7:0]} : bus_rdata;
          d.st = MV_WRITE;
          d.we = 1'b1;
          d.ram = !q.dir;
          d.addr = q.dir ? {8'h00, q.per_a} : q.ram_a;
        end
      MV_WRITE:
        if (bus_ack)
        begin
          if (q.null_write_select && !q.dir)
          begin
            d.st = MV_NULL;
            d.ram = 1'b0;
            d.addr = {8'h00, q.per_a};
            d.data = 16'h0000;
          end
          else
          begin
            d.st = MV_IDLE;
            d.req = 1'b0;
            d.we = 1'b0;
            d.done = 1'b1;
          end
        end
      MV_NULL:
        if (bus_ack)
        begin
          d.st = MV_IDLE;
          d.req = 1'b0;
          d.we = 1'b0;
          d.done = 1'b1;
        end
      default:
        d.st = MV_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= '0;
    else
      q <= d;
  end

  assign mv.done = q.done;
  assign bus_req = q.req;
  assign bus_ram = q.ram;
  assign bus_we = q.we;
  assign bus_byte = q.byte_mode;
  assign bus_addr = q.addr;
  assign bus_wdata = q.data;
endmodule : dma_mover
`default_nettype wire

// >>> dma_channel_ctrl.sv
// four-channel dma control: apb registers, triggers, arbitration, block sequencing
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dma_defines.svh"
module dma_channel_ctrl
  import dma_pkg::*;
#(
  parameter bit has_can = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [127:0] trig_lines,
  input wire logic [15:0] periph_offset,
  output logic [3:0] channel_irq,
  output logic bus_req,
  output logic bus_ram,
  output logic bus_we,
  output logic bus_byte,
  output logic [23:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack
);
  typedef struct packed {
    chan_t [3:0] ch;
    logic [3:0] pwcol;
    logic [3:0] rqcol;
    logic [3:0] lca;
    logic [23:0] last_ram_address;
    logic [3:0] irq;
    logic busy;
    logic [1:0] act;
    move_req_t x;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } top_t;
  top_t q, n;
  dma_move_if mv ();

  function automatic logic trig_hit(input logic [7:0] code, input logic [127:0] lines);
    logic hit;
    hit = code[7] ? 1'b0 : lines[code[6:0]];
    if (!has_can && (code == `TRIG_CAN_RX || code == `TRIG_CAN_TX))
      hit = 1'b0;
    return hit;
  endfunction : trig_hit

  function automatic logic mapped(input logic [7:0] a);
    return !a[7] || (a[6:5] == 2'h0 && a[4:2] <= `S_PPS);
  endfunction : mapped

  function automatic logic [23:0] buf_start(input chan_t c, input logic sel);
    return sel ? {c.stb_h, c.stb_l} : {c.sta_h, c.sta_l};
  endfunction : buf_start

  // mode field bit 1 selects ping-pong operation
  function automatic logic is_pingpong(input logic [15:0] con);
    return con[1];
  endfunction : is_pingpong

  // mode field bit 0 selects one-shot operation
  function automatic logic is_oneshot(input logic [15:0] con);
    return con[0];
  endfunction : is_oneshot

  // reserved addressing code 11 behaves as no increment
  function automatic logic is_postinc(input logic [15:0] con);
    return con[5:4] == `AM_POSTINC;
  endfunction : is_postinc

  // half mode flags the element at index count/2, full mode the last one
  function automatic logic irq_point(input chan_t c, input logic [13:0] idx);
    return c.con[`CON_HALF] ? (idx == (c.cnt >> 1)) : (idx == c.cnt);
  endfunction : irq_point

  // post-increment step is one address for bytes and two for words
  function automatic logic [23:0] step_of(input logic [15:0] con);
    return con[`CON_SIZE] ? 24'h000001 : 24'h000002;
  endfunction : step_of

  function automatic logic [15:0] rd_reg(input top_t s, input logic [7:0] a);
    chan_t c;
    logic [3:0] pp;
    logic [15:0] v;
    c = s.ch[a[6:5]];
    pp = {s.ch[3].pp, s.ch[2].pp, s.ch[1].pp, s.ch[0].pp};
    v = 16'h0000;
    if (!a[7])
    begin
      case (a[4:2])
        `R_CON: v = c.con;
        `R_REQ: v = {c.force_on, 7'h00, c.trig};
        `R_STAH: v = {8'h00, c.sta_h};
        `R_STAL: v = c.sta_l;
        `R_STBH: v = {8'h00, c.stb_h};
        `R_STBL: v = c.stb_l;
        `R_PAD: v = c.pad;
        `R_CNT: v = {2'h0, c.cnt};
        default: v = 16'h0000;
      endcase
    end
    else if (a[6:5] == 2'h0)
    begin
      case (a[4:2])
        `S_PWC: v = {12'h000, s.pwcol};
        `S_RQC: v = {12'h000, s.rqcol};
        `S_LCA: v = {12'h000, s.lca};
        `S_ADRH: v = {8'h00, s.last_ram_address[23:16]};
        `S_ADRL: v = s.last_ram_address[15:0];
        `S_PPS: v = {12'h000, pp};
        default: v = 16'h0000;
      endcase
    end
    return v;
  endfunction : rd_reg

  always_comb
  begin
    logic acc;
    logic wr;
    logic hit;
    logic taken;
    logic nxt_pp;
    logic [1:0] a;
    logic [13:0] dn;
    logic [2:0] ri;
    chan_t c;
    acc = psel && penable;
    wr = 1'b0;
    hit = 1'b0;
    taken = 1'b0;
    nxt_pp = 1'b0;
    a = q.act;
    dn = 14'h0000;
    ri = paddr[4:2];
    c = q.ch[q.act];
    n = q;
    n.irq = 4'h0;
    n.x.start = 1'b0;

    // one wait state: data is staged, then the write lands with pready high
    if (acc && !q.pready)
    begin
      n.pready = 1'b1;
      n.pslverr = !mapped(paddr);
      n.prdata = {16'h0000, rd_reg(q, paddr)};
    end
    else
    begin
      n.pready = 1'b0;
      n.pslverr = 1'b0;
    end
    wr = acc && q.pready && pwrite && mapped(paddr);

    // block sequencing on completion of one element
    // an element in flight completes even if its channel was disabled meanwhile
    if (mv.done)
    begin
      n.busy = 1'b0;
      n.last_ram_address = q.x.ram_addr;
      n.lca = {2'h0, a};
      if (q.x.forced)
        n.ch[a].force_on = 1'b0;
      dn = c.done;
      if (is_postinc(c.con))
        n.ch[a].cur = c.cur + step_of(c.con);
      if (irq_point(c, dn))
        n.irq[a] = 1'b1;
      if (dn == c.cnt)
      begin
        n.ch[a].done = 14'h0000;
        nxt_pp = is_pingpong(c.con) ? !c.pp : c.pp;
        n.ch[a].pp = nxt_pp;
        n.ch[a].cur = buf_start(c, nxt_pp);
        if (is_oneshot(c.con) && (!is_pingpong(c.con) || c.pp))
          n.ch[a].con[`CON_CHANNEL_ON] = 1'b0;
      end
      else
        n.ch[a].done = dn + 14'h0001;
    end

    // register writes; software beats the hardware enable clear
    if (wr && !paddr[7])
    begin
      a = paddr[6:5];
      c = q.ch[a];
      case (ri)
        `R_CON:
        begin
          n.ch[a].con = pwdata[15:0] & `CON_WMASK;
          if (pwdata[`CON_CHANNEL_ON] && !c.con[`CON_CHANNEL_ON])
          begin
            n.ch[a].cur = {c.sta_h, c.sta_l};
            n.ch[a].done = 14'h0000;
            n.ch[a].pp = 1'b0;
          end
        end
        `R_REQ:
        begin
          n.ch[a].trig = pwdata[7:0];
          if (pwdata[`REQ_FORCE] && n.ch[a].con[`CON_CHANNEL_ON])
            n.ch[a].force_on = 1'b1;
        end
        `R_STAH: n.ch[a].sta_h = pwdata[7:0];
        `R_STAL: n.ch[a].sta_l = pwdata[15:0];
        `R_STBH: n.ch[a].stb_h = pwdata[7:0];
        `R_STBL: n.ch[a].stb_l = pwdata[15:0];
        `R_PAD: n.ch[a].pad = pwdata[15:0];
        `R_CNT: n.ch[a].cnt = pwdata[13:0];
        default: n.ch[a].pad = q.ch[a].pad;
      endcase
    end

    // collision flags clear on a write of one; a new event still wins
    if (wr && paddr[7] && ri == `S_PWC)
      n.pwcol = q.pwcol & ~pwdata[3:0];
    if (wr && paddr[7] && ri == `S_RQC)
      n.rqcol = q.rqcol & ~pwdata[3:0];

    // fixed priority: lowest numbered pending channel goes first
    if (!q.busy)
    begin
      for (int i = 3; i >= 0; i--)
      begin
        if (q.ch[i].pend && q.ch[i].con[`CON_CHANNEL_ON])
        begin
          taken = 1'b1;
          a = 2'(i);
        end
      end
    end
    if (taken)
    begin
      c = q.ch[a];
      n.busy = 1'b1;
      n.act = a;
      n.ch[a].pend = 1'b0;
      n.x.start = 1'b1;
      n.x.forced = c.force_on;
      n.x.dir = c.con[`CON_DIR];
      n.x.byte_mode = c.con[`CON_SIZE];
      n.x.null_write_select = c.con[`CON_NULL_WRITE_SELECT];
      n.x.per_addr = c.pad;
      if (c.con[5:4] == `AM_PERIND)
        n.x.ram_addr = buf_start(c, c.pp) + {8'h00, periph_offset};
      else
        n.x.ram_addr = c.cur;
    end

    // triggers and force raise pending requests, one per channel at a time
    // a trigger level held for several cycles raises one request per cycle
    for (int i = 0; i < `CH_NUM; i++)
    begin
      hit = trig_hit(q.ch[i].trig, trig_lines) && q.ch[i].con[`CON_CHANNEL_ON];
      // a trigger that meets a waiting forced request is dropped
      if (q.ch[i].force_on && hit)
        n.rqcol[i] = 1'b1;
      // only the rising force bit requests; holding it set adds nothing
      else if (hit || (n.ch[i].force_on && !q.ch[i].force_on))
      begin
        if (n.ch[i].pend)
          n.pwcol[i] = 1'b1;
        n.ch[i].pend = 1'b1;
      end
      if (!n.ch[i].con[`CON_CHANNEL_ON])
      begin
        n.ch[i].force_on = 1'b0;
        n.ch[i].pend = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q <= '0;
      q.lca <= `LCA_RESET;
    end
    else
      q <= n;
  end

  assign mv.start = q.x.start;
  assign mv.dir = q.x.dir;
  assign mv.byte_mode = q.x.byte_mode;
  assign mv.null_write_select = q.x.null_write_select;
  assign mv.ram_addr = q.x.ram_addr;
  assign mv.per_addr = q.x.per_addr;
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign channel_irq = q.irq;

  // one mover serves all channels, so only one element is ever on the bus
  dma_mover u_mover (
    .pclk(pclk),
    .presetn(presetn),
    .mv(mv.mover),
    .bus_req(bus_req),
    .bus_ram(bus_ram),
    .bus_we(bus_we),
    .bus_byte(bus_byte),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .bus_ack(bus_ack)
  );
endmodule : dma_channel_ctrl
`default_nettype wire

// >>> dma_ctrl_chk.sv
// port assertions for the dma channel control block
`timescale 1ns/1ps
`default_nettype none
module dma_ctrl_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] channel_irq,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_ack
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && $rose(penable) |=> pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready && paddr >= 8'h98 |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (pready && paddr < 8'h80 |-> !pslverr)
    else $error("error on channel register");
  a_top_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_req_hold: assert property (bus_req && !bus_ack |=>
    bus_req && $stable({bus_we, bus_addr, bus_wdata}))
    else $error("element request changed before ack");
  a_read_first: assert property ($rose(bus_req) |-> !bus_we)
    else $error("element did not start with a read");
  a_irq_pulse: assert property (channel_irq != 4'h0 |=> channel_irq == 4'h0)
    else $error("interrupt longer than one cycle");
  a_irq_single: assert property ($onehot0(channel_irq))
    else $error("two channels finished at once");
endmodule : dma_ctrl_chk
bind dma_channel_ctrl dma_ctrl_chk i_chk (.pclk, .presetn, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .channel_irq, .bus_req, .bus_we,
  .bus_addr, .bus_wdata, .bus_ack);
`default_nettype wire

// >>> bus_partner.sv
// far side of the element bus: ram and peripheral space with a set stall
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_req,
  input wire logic [23:0] bus_addr,
  input wire logic [3:0] stall,
  output logic [15:0] bus_rdata,
  output logic bus_ack
);
  logic [3:0] wait_q;
  // data toggles outside the answer cycle so a late sample cannot pass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bus_ack <= 1'b0;
      wait_q <= 4'h0;
      bus_rdata <= 16'h0000;
    end
    else if (!bus_ack && bus_req && wait_q >= stall)
    begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_addr[15:0] ^ 16'h5A5A;
      wait_q <= 4'h0;
    end
    else
    begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      wait_q <= (bus_req && !bus_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule : bus_partner
`default_nettype wire

// >>> four_channel_dma_channel_control_bench.sv
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
`default_nettype none
module four_channel_dma_channel_control_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [127:0] trig_lines = 128'h0;
  logic [3:0] stall = 4'h0;
  logic [15:0] periph_offset = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, bus_req, bus_ram, bus_we, bus_byte, bus_ack;
  logic [3:0] channel_irq;
  logic [23:0] bus_addr;
  logic [15:0] bus_wdata, bus_rdata;
  logic [42:0] acc_q[$];
  int miscompares = 0;
  int n_compared = 0;
  int irq_n[4] = '{0, 0, 0, 0};
  always #50 pclk = ~pclk;
  dma_channel_ctrl i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .trig_lines, .periph_offset,
    .channel_irq, .bus_req, .bus_ram, .bus_we, .bus_byte, .bus_addr, .bus_wdata,
    .bus_rdata, .bus_ack);
  bus_partner i_far (.pclk, .presetn, .bus_req, .bus_addr, .stall, .bus_rdata,
    .bus_ack);
  always @(posedge pclk)
  begin
    if (bus_req === 1'b1 && bus_ack === 1'b1)
      acc_q.push_back({bus_ram, bus_we, bus_byte, bus_addr,
        bus_we ? (bus_byte ? {8'h00, bus_wdata[7:0]} : bus_wdata) : 16'h0000});
    for (int k = 0; k < 4; k++)
      if (channel_irq[k] === 1'b1)
        irq_n[k]++;
  end
  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string s, input logic [42:0] x, input logic [42:0] g);
    n_compared++;
    if (g !== x)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("wrong value pready expected 1 seen %b", pready);
    end
    r = prdata[15:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [15:0] x);
    logic [15:0] r;
    logic e;
    apb(1'b0, a, 16'h0000, r, e);
    chk($sformatf("register %h", a), {27'h0, x}, {27'h0, r});
  endtask : rc
  task automatic acc(input logic [42:0] x);
    int n;
    logic [42:0] g;
    n = 0;
    while (acc_q.size() == 0 && n < 300)
    begin
      @(posedge pclk);
      n++;
    end
    g = (acc_q.size() > 0) ? acc_q.pop_front() : 43'hX;
    chk("element access", x, g);
  endtask : acc
  task automatic irq_wait(input int k, input int x);
    int n;
    n = 0;
    while (irq_n[k] < x && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    chk("interrupt count", 43'(x), 43'(irq_n[k]));
  endtask : irq_wait
  task automatic pulse(input int b);
    trig_lines[b] <= 1'b1;
    @(posedge pclk);
    trig_lines[b] <= 1'b0;
    @(posedge pclk);
  endtask : pulse
  task automatic setup(input logic [7:0] b, input logic [23:0] s,
    input logic [15:0] p, input logic [15:0] c, input logic [15:0] q,
    input logic [15:0] k);
    wr(b + 8'h08, {8'h00, s[23:16]});
    wr(b + 8'h0C, s[15:0]);
    wr(b + 8'h18, p);
    wr(b + 8'h1C, c);
    wr(b + 8'h04, q);
    wr(b, k);
  endtask : setup
  task automatic t_reset;
    rc(8'h00, 16'h0000);
    rc(8'h7C, 16'h0000);
    rc(8'h88, 16'h000F);
  endtask : t_reset
  task automatic t_regs;
    logic [7:0] ra[5] = '{8'h60, 8'h68, 8'h70, 8'h7C, 8'h64};
    logic [15:0] rx[5] = '{16'h7833, 16'h00FF, 16'h00FF, 16'h3FFF, 16'h00FF};
    logic [15:0] r;
    logic e;
    for (int i = 0; i < 5; i++)
    begin
      wr(ra[i], 16'h7FFF | {i != 0, 15'h0});
      rc(ra[i], rx[i]);
    end
    apb(1'b0, 8'h98, 16'h0000, r, e);
    chk("unmapped error", 43'h1, {42'h0, e});
  endtask : t_regs
  task automatic t_force;
    stall <= 4'h6;
    setup(8'h00, 24'h012344, 16'h0248, 16'h0000, 16'h000A, 16'h8001);
    wr(8'h04, 16'h800A);
    wr(8'h04, 16'h000A);
    rc(8'h04, 16'h800A);
    acc({3'b000, 24'h000248, 16'h0000});
    acc({3'b110, 24'h012344, 16'h5812});
    irq_wait(0, 1);
    rc(8'h04, 16'h000A);
    rc(8'h00, 16'h0001);
    rc(8'h88, 16'h0000);
    rc(8'h8C, 16'h0001);
    rc(8'h90, 16'h2344);
    chk("extra accesses", 43'h0, 43'(acc_q.size()));
  endtask : t_force
  task automatic t_pp;
    logic [15:0] a;
    stall <= 4'h2;
    wr(8'h30, 16'h0000);
    wr(8'h34, 16'h2000);
    setup(8'h20, 24'h001000, 16'h0224, 16'h0001, 16'h000D, 16'hF002);
    for (int i = 0; i < 4; i++)
    begin
      a = (i < 2 ? 16'h1000 : 16'h2000) + {15'h0, i[0]};
      pulse(13);
      acc({3'b101, 8'h00, a, 16'h0000});
      acc({3'b011, 24'h000224, 8'h00, a[7:0] ^ 8'h5A});
      irq_wait(1, i / 2 + 1);
    end
    rc(8'h20, 16'hF002);
    wr(8'h20, 16'h0000);
  endtask : t_pp
  task automatic t_null;
    stall <= 4'h0;
    // direction stays clear while null write is on
    setup(8'h40, 24'h003000, 16'h0300, 16'h0001, 16'h0000, 16'h8810);
    repeat (2)
    begin
      pulse(0);
      acc({3'b000, 24'h000300, 16'h0000});
      acc({3'b110, 24'h003000, 16'h595A});
      acc({3'b010, 24'h000300, 16'h0000});
    end
    irq_wait(2, 1);
    wr(8'h40, 16'h0000);
  endtask : t_null
  task automatic t_addressing_select;
    stall <= 4'h3;
    periph_offset <= 16'h0010;
    setup(8'h40, 24'h004000, 16'h0226, 16'h0001, 16'h000B, 16'h8001);
    for (int i = 0; i < 2; i++)
    begin
      pulse(11);
      acc({3'b000, 24'h000226, 16'h0000});
      acc({3'b110, 24'h004000 + 24'(2 * i), 16'h587C});
    end
    irq_wait(2, 2);
    setup(8'h40, 24'h004000, 16'h0226, 16'h0000, 16'h000B, 16'h8021);
    pulse(11);
    acc({3'b000, 24'h000226, 16'h0000});
    acc({3'b110, 24'h004010, 16'h587C});
    irq_wait(2, 3);
    rc(8'h40, 16'h0021);
    rc(8'h90, 16'h4010);
  endtask : t_addressing_select
  task automatic t_prio;
    stall <= 4'h1;
    setup(8'h00, 24'h005000, 16'h0100, 16'h0000, 16'h0007, 16'h8001);
    setup(8'h60, 24'h006000, 16'h0200, 16'h0000, 16'h0007, 16'h8001);
    pulse(7);
    acc({3'b000, 24'h000100, 16'h0000});
    acc({3'b110, 24'h005000, 16'h5B5A});
    acc({3'b000, 24'h000200, 16'h0000});
    acc({3'b110, 24'h006000, 16'h585A});
  endtask : t_prio
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_regs;
    t_force;
    t_pp;
    t_null;
    t_addressing_select;
    t_prio;
    tally_and_finish;
  end
  initial
  begin
    #2000000;
    miscompares++;
    tally_and_finish;
  end
endmodule : four_channel_dma_channel_control_bench
`default_nettype wire
